// >>> cpr_checker_assertions.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks of the readout control.
// ============================================================
module cpr_checker
(
  input wire logic                      ref_clk_in,
  input wire logic                      rst_n_in,
  input wire logic                      chip_select_n_in,
  input wire logic                      oe_reset_n_in,
  input wire logic                      oe_reset_n_out,
  input wire logic                      oe_reset_n_oe_n_out,
  input wire logic                      config_pulse_n_in,
  input wire logic                      config_pulse_n_oe_n_out,
  input wire logic                      reload_config_in,
  input wire logic                      revision_source_pin_mode_in,
  input wire logic                      revision_pick_bit0_in,
  input wire logic                      revision_pick_bit1_in,
  input wire logic [cpr_pkg::REV_W-1:0] internal_revision_in,
  input wire logic                      serial_mode_in,
  input wire logic                      serial_config_data_oe_n_out,
  input wire logic [cpr_pkg::UPPER_W-1:0] upper_parallel_data_out,
  input wire logic                      upper_parallel_data_oe_n_out,
  input wire logic                      forwarded_config_clock_out,
  input wire logic                      forwarded_config_clock_oe_n_out,
  input wire logic                      cascade_enable_out_n_out,
  input wire logic                      standby_out,
  input wire logic [cpr_pkg::REV_W-1:0] active_revision_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Counts pulse cycles so the full length can be checked without a long repeat.
  logic [5:0] low_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      low_q <= 6'h0;
    else
      low_q <= config_pulse_n_oe_n_out ? 6'h0 : low_q + 6'h1;

  AST_OD_LOW: assert property (oe_reset_n_out == 1'b0)
    else $error("open-drain data level not low");
  AST_OWN_RST: assert property ($rose(rst_n_in) |-> !oe_reset_n_oe_n_out)
    else $error("reset wire not held low in reset");
  AST_PULSE_GO: assert property (reload_config_in && config_pulse_n_oe_n_out
    |=> !config_pulse_n_oe_n_out)
    else $error("reload did not start the pulse");
  AST_PULSE_LEN: assert property ($rose(config_pulse_n_oe_n_out) |-> low_q == 6'h14)
    else $error("pulse length wrong");
  AST_CS_OFF: assert property (chip_select_n_in [*5] |=> standby_out
    && serial_config_data_oe_n_out && upper_parallel_data_oe_n_out
    && forwarded_config_clock_oe_n_out && cascade_enable_out_n_out)
    else $error("deselect did not release outputs");
  AST_OE_OFF: assert property (!oe_reset_n_in [*5] |=> serial_config_data_oe_n_out
    && forwarded_config_clock_oe_n_out && cascade_enable_out_n_out)
    else $error("reset wire low did not release outputs");
  AST_SER_UP: assert property (serial_mode_in [*2]
    |-> upper_parallel_data_oe_n_out && upper_parallel_data_out == 7'h0)
    else $error("upper data driven in serial mode");
  AST_FCLK_ONE: assert property (forwarded_config_clock_out |=> !forwarded_config_clock_out)
    else $error("forwarded clock high too long");
  AST_FCLK_ACT: assert property (forwarded_config_clock_out |-> !serial_config_data_oe_n_out)
    else $error("forwarded clock while data released");
  AST_CEO_ACT: assert property (!cascade_enable_out_n_out
    |-> !standby_out && !serial_config_data_oe_n_out)
    else $error("cascade low while not reading");
  AST_REV_PINS: assert property ((!config_pulse_n_in && config_pulse_n_oe_n_out
    && !revision_source_pin_mode_in
    && $stable({revision_pick_bit1_in, revision_pick_bit0_in})) [*4]
    |-> ##2 active_revision_out == $past({revision_pick_bit1_in, revision_pick_bit0_in}, 2))
    else $error("revision pins not taken");
  AST_REV_INT: assert property ((!config_pulse_n_in && config_pulse_n_oe_n_out
    && revision_source_pin_mode_in && $stable(internal_revision_in)) [*4]
    |-> ##2 active_revision_out == $past(internal_revision_in, 2))
    else $error("internal revision not taken");

  cover property (!cascade_enable_out_n_out);
  cover property (forwarded_config_clock_out && serial_mode_in);
  cover property (!config_pulse_n_oe_n_out);
endmodule // cpr_checker

bind cpr_top cpr_checker chk (.*);

// >>> cpr_fpga_model.sv
`timescale 1ns/1ps
// ============================================================
// Configuration port of the receiving logic device.
// ============================================================
module cpr_fpga_model
(
  input  wire logic       ref_clk_in,
  input  wire logic       dev_oe_n_in,
  input  wire logic       fclk_in,
  input  wire logic       serial_in,
  input  wire logic [7:0] data_in,
  output logic            cfg_clk_out,
  output logic            chip_select_n_out,
  output logic            oe_wire_out,
  output logic            busy_out
);
  logic       rel_q = 1'b1;
  logic [7:0] sh_q;
  int         nb = 0;
  logic [7:0] got[$];
  initial
  begin
    cfg_clk_out = 1'b0;
    chip_select_n_out = 1'b1;
    busy_out = 1'b0;
  end
  assign oe_wire_out = dev_oe_n_in & rel_q;
  task automatic sel(input logic cs_n, input logic rel);
    chip_select_n_out = cs_n;
    rel_q = rel;
  endtask
  task automatic bsy(input logic b);
    busy_out = b;
  endtask
  task automatic clr();
    got.delete();
    nb = 0;
  endtask
  // clock runs only within a read, slow enough to be seen.
  task automatic ticks(input int n);
    repeat (n)
    begin
      repeat (3) @(negedge ref_clk_in);
      cfg_clk_out = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      cfg_clk_out = 1'b0;
    end
  endtask
  // capture, serial words MSB first.
  // Sampled at the falling edge, where the registered outputs have settled.
  always @(negedge ref_clk_in)
    if (fclk_in && serial_in)
    begin
      sh_q = {sh_q[6:0], data_in[0]};
      nb = (nb + 1) % 8;
      if (nb == 0)
        got.push_back(sh_q);
    end
    else if (fclk_in)
      got.push_back(data_in);
endmodule // cpr_fpga_model

// >>> cpr_mem.sv
`timescale 1ns/1ps
module cpr_mem
(
  input  wire logic                            ref_clk_in,
  input  wire logic                            rst_n_in,
  input  wire logic                            clk_en_in,
  input  wire logic                            wr_en_in,
  input  wire logic [cpr_pkg::MEM_AW-1:0]      wr_addr_in,
  input  wire logic [cpr_pkg::WORD_W-1:0]      wr_data_in,
  input  wire logic                            rd_en_in,
  input  wire logic [cpr_pkg::MEM_AW-1:0]      rd_addr_in,
  output logic      [cpr_pkg::WORD_W-1:0]      rd_data_out
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // The array has no reset so that it maps onto plain memory.
  logic [cpr_pkg::WORD_W-1:0] mem_q [cpr_pkg::MEM_DEPTH];

  always_ff @(posedge ref_clk_in)
  begin
    if (clk_en_in && wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= '0;
    end
    else if (clk_en_in && rd_en_in)
    begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule // cpr_mem

// >>> cpr_pkg.sv
// How it works
// - A control bit picks internal oscillator or external clock pin as source.
// - External clock selected, enabled, not reset: each rising edge advances address; in serial mode the code advances it on every eighth edge.
// - Reset pin low: counter held reset, data and clock outputs released.
// - Reset pin is open-drain, driven low during own reset, fixed polarity.
// - Chip select high: standby, counter reset, data and clock outputs released.
// - Reload command drives a low pulse on the configuration pulse pin.
// - Configuration pulse pin sensed low samples the selected design revision.
// - Cascade output low only when enabled, not reset, and past terminal count.
// - Cascade output returns high on reset low or chip select high.
// - Source pin low uses revision pins; high uses internal revision bits.
// - Two-bit revision pin field picks the revision while the source pin is low.
// - Serial mode drives data on the lowest output only, upper seven released.
// - Parallel mode: busy high stalls the counter; next data after busy falls.
// - Forwarded clock rises with valid data and stays low otherwise.
package cpr_pkg;

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned WORD_W        = 8;
  localparam int unsigned UPPER_W       = 7;
  localparam int unsigned REV_W         = 2;
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned MEM_AW        = REV_W + ADDR_W;
  localparam int unsigned MEM_DEPTH     = 256;
  localparam int unsigned FIFO_DEPTH    = 2;

  localparam logic [ADDR_W-1:0] TERMINAL_COUNT = 6'h3f;
  localparam logic [2:0]        BIT_FIRST      = 3'h1;
  localparam logic [1:0]        FIFO_FULL      = 2'h2;

  // Internal oscillator period; a longest interval rounds down, at least one cycle.
  localparam int unsigned OSC_PERIOD_NS = 100;
  localparam int unsigned OSC_CYC_I     = (OSC_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                          (OSC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [3:0]  OSC_LAST      = 4'(OSC_CYC_I - 1);

  // Configuration pulse low time; a least interval rounds up.
  localparam int unsigned CFG_PULSE_NS  = 500;
  localparam int unsigned CFG_PULSE_I   = (CFG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  CFG_PULSE_CYC = 5'(CFG_PULSE_I);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    CPR_ST_STANDBY = 3'h1,
    CPR_ST_RESET   = 3'h2,
    CPR_ST_ACTIVE  = 3'h4
  } cpr_mode_t;

  // Pins from outside the clock domain, synchronised together.
  typedef struct packed {
    logic             ext_clk;
    logic             chip_sel_n;
    logic             oe_reset_n;
    logic             busy;
    logic             cfg_pulse_n;
    logic             src_pin_mode;
    logic [REV_W-1:0] pick;
  } cpr_pins_t;

  typedef struct packed {
    cpr_mode_t                       mode;
    cpr_pins_t                       s1;
    cpr_pins_t                       s2;
    logic                            ext_prev;
    logic [3:0]                      osc_cnt;
    logic [ADDR_W-1:0]               fetch_addr;
    logic                            rd_pend;
    logic [FIFO_DEPTH-1:0][WORD_W-1:0] fifo;
    logic                            wp;
    logic                            rp;
    logic [1:0]                      fcnt;
    logic [ADDR_W-1:0]               count;
    logic                            tc_passed;
    logic [WORD_W-1:0]               data;
    logic [WORD_W-1:0]               shreg;
    logic [2:0]                      bit_idx;
    logic                            fclk;
    logic [REV_W-1:0]                rev_active;
    logic [4:0]                      pulse_cnt;
  } cpr_state_t;

  // Synchronisers wake at the pins' idle levels, so no false select or pulse follows reset.
  localparam cpr_pins_t PINS_IDLE = '{chip_sel_n: 1'b1, oe_reset_n: 1'b1, cfg_pulse_n: 1'b1,
                                      default: '0};

  localparam cpr_state_t STATE_RST = '{mode: CPR_ST_STANDBY, s1: PINS_IDLE, s2: PINS_IDLE,
                                       default: '0};

endpackage

// >>> cpr_top.sv
`timescale 1ns/1ps
module cpr_top
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          clk_en_in,
  input  wire logic                          cfg_clk_in,
  input  wire logic                          chip_select_n_in,
  input  wire logic                          oe_reset_n_in,
  output logic                               oe_reset_n_out,
  output logic                               oe_reset_n_oe_n_out,
  input  wire logic                          config_pulse_n_in,
  output logic                               config_pulse_n_out,
  output logic                               config_pulse_n_oe_n_out,
  input  wire logic                          busy_in,
  input  wire logic                          revision_source_pin_mode_in,
  input  wire logic                          revision_pick_bit0_in,
  input  wire logic                          revision_pick_bit1_in,
  input  wire logic                          clk_source_internal_in,
  input  wire logic [cpr_pkg::REV_W-1:0]     internal_revision_in,
  input  wire logic                          serial_mode_in,
  input  wire logic                          forwarded_config_clock_enable_in,
  input  wire logic                          reload_config_in,
  input  wire logic                          prog_wr_en_in,
  input  wire logic [cpr_pkg::MEM_AW-1:0]    prog_addr_in,
  input  wire logic [cpr_pkg::WORD_W-1:0]    prog_data_in,
  output logic                               serial_config_data_out,
  output logic                               serial_config_data_oe_n_out,
  output logic      [cpr_pkg::UPPER_W-1:0]   upper_parallel_data_out,
  output logic                               upper_parallel_data_oe_n_out,
  output logic                               forwarded_config_clock_out,
  output logic                               forwarded_config_clock_oe_n_out,
  output logic                               cascade_enable_out_n_out,
  output logic                               standby_out,
  output logic      [cpr_pkg::REV_W-1:0]     active_revision_out
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_q;
  logic       rst_ok;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync_q <= 2'h0;
    end
    else if (clk_en_in)
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_ok = rst_sync_q[1];

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [cpr_pkg::REV_W-1:0] pick_revision(
    input logic                      src_pin_mode,
    input logic [cpr_pkg::REV_W-1:0] pins,
    input logic [cpr_pkg::REV_W-1:0] internal_bits
  );
    return src_pin_mode ? internal_bits : pins;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  cpr_pkg::cpr_state_t s_q;
  cpr_pkg::cpr_state_t s_d;
  cpr_pkg::cpr_pins_t  pins_raw;
  logic [cpr_pkg::WORD_W-1:0] rd_data;
  logic                       rd_issue;
  logic [cpr_pkg::MEM_AW-1:0] rd_addr;
  logic                       active;

  assign pins_raw = '{ext_clk:      cfg_clk_in,
                      chip_sel_n:   chip_select_n_in,
                      oe_reset_n:   oe_reset_n_in,
                      busy:         busy_in,
                      cfg_pulse_n:  config_pulse_n_in,
                      src_pin_mode: revision_source_pin_mode_in,
                      pick:         {revision_pick_bit1_in, revision_pick_bit0_in}};

  assign active = (s_q.mode == cpr_pkg::CPR_ST_ACTIVE);

  always_comb
  begin
    logic       tick;
    logic       advance_ok;
    logic       pop;
    logic       push;
    logic       shift;
    logic [1:0] occupancy;
    logic [cpr_pkg::WORD_W-1:0] head;
    tick       = 1'b0;
    advance_ok = 1'b0;
    pop        = 1'b0;
    push       = 1'b0;
    shift      = 1'b0;
    occupancy  = 2'h0;
    head       = '0;
    rd_issue   = 1'b0;
    s_d        = s_q;
    s_d.fclk   = 1'b0;

    // Two flops on every pin; only the second copy is read below.
    s_d.s1       = pins_raw;
    s_d.s2       = s_q.s1;
    s_d.ext_prev = s_q.s2.ext_clk;

    // Standby outranks reset, which outranks normal reading.
    if (s_q.s2.chip_sel_n)
    begin
      s_d.mode = cpr_pkg::CPR_ST_STANDBY;
    end
    else if (!s_q.s2.oe_reset_n)
    begin
      s_d.mode = cpr_pkg::CPR_ST_RESET;
    end
    else
    begin
      s_d.mode = cpr_pkg::CPR_ST_ACTIVE;
    end

    if (s_q.osc_cnt == cpr_pkg::OSC_LAST)
    begin
      s_d.osc_cnt = '0;
    end
    else
    begin
      s_d.osc_cnt = s_q.osc_cnt + 4'h1;
    end
    if (clk_source_internal_in)
    begin
      tick = (s_q.osc_cnt == cpr_pkg::OSC_LAST);
    end
    else
    begin
      tick = s_q.s2.ext_clk && !s_q.ext_prev;
    end

    advance_ok = active && (serial_mode_in || !s_q.s2.busy);

    head = s_q.fifo[s_q.rp];
    unique case (s_q.mode)
      cpr_pkg::CPR_ST_STANDBY,
      cpr_pkg::CPR_ST_RESET:
      begin
        s_d.fetch_addr = '0;
        s_d.rd_pend    = 1'b0;
        s_d.wp         = 1'b0;
        s_d.rp         = 1'b0;
        s_d.fcnt       = '0;
        s_d.count      = '0;
        s_d.tc_passed  = 1'b0;
        s_d.bit_idx    = '0;
        s_d.data       = '0;
        s_d.shreg      = '0;
      end
      cpr_pkg::CPR_ST_ACTIVE:
      begin
        if (tick && advance_ok)
        begin
          if (serial_mode_in && (s_q.bit_idx != 3'h0))
          begin
            shift = 1'b1;
          end
          else
          begin
            // The address moves only while a word is waiting.
            pop = (s_q.fcnt != 2'h0);
          end
        end
        push      = s_q.rd_pend;
        occupancy = s_q.fcnt + {1'b0, s_q.rd_pend};
        // Room is counted with the read in flight, so a stalled drain stops fetching.
        rd_issue  = (occupancy < cpr_pkg::FIFO_FULL);
        if (push)
        begin
          s_d.fifo[s_q.wp] = rd_data;
          s_d.wp           = !s_q.wp;
        end
        if (rd_issue)
        begin
          s_d.fetch_addr = s_q.fetch_addr + 6'h01;
        end
        s_d.rd_pend = rd_issue;
        if (pop)
        begin
          s_d.rp    = !s_q.rp;
          s_d.count = s_q.count + 6'h01;
          if (s_q.count == cpr_pkg::TERMINAL_COUNT)
          begin
            s_d.tc_passed = 1'b1;
          end
          s_d.fclk = 1'b1;
          if (serial_mode_in)
          begin
            // bits leave on the lowest line
            s_d.data    = {{cpr_pkg::UPPER_W{1'b0}}, head[cpr_pkg::WORD_W-1]};
            s_d.shreg   = {head[cpr_pkg::WORD_W-2:0], 1'b0};
            s_d.bit_idx = cpr_pkg::BIT_FIRST;
          end
          else
          begin
            s_d.data = head;
          end
        end
        if (shift)
        begin
          s_d.fclk    = 1'b1;
          s_d.data    = {{cpr_pkg::UPPER_W{1'b0}}, s_q.shreg[cpr_pkg::WORD_W-1]};
          s_d.shreg   = {s_q.shreg[cpr_pkg::WORD_W-2:0], 1'b0};
          s_d.bit_idx = s_q.bit_idx + 3'h1;
        end
        unique case ({push, pop})
          2'b10:   s_d.fcnt = s_q.fcnt + 2'h1;
          2'b01:   s_d.fcnt = s_q.fcnt - 2'h1;
          default: s_d.fcnt = s_q.fcnt;
        endcase
      end
      default:
      begin
        s_d.mode = cpr_pkg::CPR_ST_STANDBY;
      end
    endcase

    if (reload_config_in)
    begin
      s_d.pulse_cnt = cpr_pkg::CFG_PULSE_CYC;
    end
    else if (s_q.pulse_cnt != 5'h00)
    begin
      s_d.pulse_cnt = s_q.pulse_cnt - 5'h01;
    end

    // sample revision on low
    // Our own pulse is ignored only while driven, so a reload does not resample mid-drive; its last two synchronised cycles still sample.
    if (!s_q.s2.cfg_pulse_n && (s_q.pulse_cnt == 5'h00))
    begin
      s_d.rev_active = pick_revision(s_q.s2.src_pin_mode, s_q.s2.pick, internal_revision_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      s_q <= cpr_pkg::STATE_RST;
    end
    else if (clk_en_in)
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Stored words
  // ==========================================================================
  // counter picks the word
  assign rd_addr = {s_q.rev_active, s_q.fetch_addr};

  cpr_mem u_mem
  (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_ok),
    .clk_en_in   (clk_en_in),
    .wr_en_in    (prog_wr_en_in),
    .wr_addr_in  (prog_addr_in),
    .wr_data_in  (prog_data_in),
    .rd_en_in    (rd_issue),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data)
  );

  // ==========================================================================
  // Pins
  // ==========================================================================
  // drive low while in reset
  assign oe_reset_n_out                  = 1'b0;
  assign oe_reset_n_oe_n_out             = rst_ok;
  assign config_pulse_n_out              = 1'b0;
  assign config_pulse_n_oe_n_out         = (s_q.pulse_cnt == 5'h00);
  assign serial_config_data_out          = s_q.data[0];
  assign upper_parallel_data_out         = s_q.data[cpr_pkg::WORD_W-1:1];
  assign serial_config_data_oe_n_out     = !active;
  assign upper_parallel_data_oe_n_out    = !(active && !serial_mode_in);
  assign forwarded_config_clock_out      = s_q.fclk && active;
  assign forwarded_config_clock_oe_n_out = !(active && forwarded_config_clock_enable_in);
  assign cascade_enable_out_n_out        = !(active && s_q.tc_passed);
  assign standby_out                     = (s_q.mode == cpr_pkg::CPR_ST_STANDBY);
  assign active_revision_out             = s_q.rev_active;

endmodule // cpr_top

// >>> tb_config_prom_readout_control.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module tb_config_prom_readout_control;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cf_drv = 1'b1, src = 1'b0, b0 = 1'b0, b1 = 1'b0;
  logic       clk_int = 1'b0, ser = 1'b0, reload = 1'b0, wr = 1'b0;
  logic       clk_en = 1'b1, ckoe = 1'b1;
  logic [1:0] irev = 2'h0;
  logic [7:0] wa = 8'h0, wd = 8'h0;
  wire        cfg_clk, cs_n, oe_w, busy, oe_n, cf_out, cf_oe_n, d0, d0_oe_n;
  wire        up_oe_n, fck, fck_oe_n, ceo_n, stby, od0;
  wire  [6:0] up;
  wire  [1:0] arev;
  wire        cf_w = cf_oe_n & cf_drv;
  int         n_mismatch = 0, cmp_count = 0, n;

  always #12.5 clk = ~clk;

  cpr_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en), .cfg_clk_in(cfg_clk),
    .chip_select_n_in(cs_n), .oe_reset_n_in(oe_w), .oe_reset_n_out(od0),
    .oe_reset_n_oe_n_out(oe_n), .config_pulse_n_in(cf_w), .config_pulse_n_out(cf_out),
    .config_pulse_n_oe_n_out(cf_oe_n), .busy_in(busy), .revision_source_pin_mode_in(src),
    .revision_pick_bit0_in(b0), .revision_pick_bit1_in(b1), .clk_source_internal_in(clk_int),
    .internal_revision_in(irev), .serial_mode_in(ser), .forwarded_config_clock_enable_in(ckoe),
    .reload_config_in(reload), .prog_wr_en_in(wr), .prog_addr_in(wa), .prog_data_in(wd),
    .serial_config_data_out(d0), .serial_config_data_oe_n_out(d0_oe_n),
    .upper_parallel_data_out(up), .upper_parallel_data_oe_n_out(up_oe_n),
    .forwarded_config_clock_out(fck), .forwarded_config_clock_oe_n_out(fck_oe_n),
    .cascade_enable_out_n_out(ceo_n), .standby_out(stby), .active_revision_out(arev));

  cpr_fpga_model fpga (.ref_clk_in(clk), .dev_oe_n_in(oe_n), .fclk_in(fck), .serial_in(ser),
    .data_in({up, d0}), .cfg_clk_out(cfg_clk), .chip_select_n_out(cs_n),
    .oe_wire_out(oe_w), .busy_out(busy));

  function automatic logic [7:0] wexp(input int r, input int a);
    return 8'(r * 64 + a) ^ 8'ha5;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pick(input logic s, input logic [1:0] p);
    src = s;
    {b1, b0} = p;
    cyc(2);
    cf_drv = 1'b0;
    cyc(6);
    cf_drv = 1'b1;
    cyc(4);
  endtask
  task automatic open_rd();
    fpga.clr();
    fpga.sel(1'b0, 1'b1);
    cyc(12);
  endtask
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    cyc(4);
    `CHK("rst_drive", 1'b0, oe_n)
    `CHK("rst_ceo", 1'b1, ceo_n)
    `CHK("rst_lvl", 1'b0, od0)
    rst_n = 1'b1;
    cyc(10);
    `CHK("standby", 1'b1, stby)
    `CHK("d0_rel", 1'b1, d0_oe_n)
    `CHK("rst_free", 1'b1, oe_n)
    for (int i = 0; i < 256; i++)
    begin
      wr = 1'b1;
      wa = 8'(i);
      wd = wexp(0, i);
      cyc(1);
    end
    wr = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      pick(1'b0, 2'(p));
      `CHK("rev_pins", 2'(p), arev)
    end
    irev = 2'h1;
    pick(1'b1, 2'h3);
    `CHK("rev_int", 2'h1, arev)
    $display("test revision done");
    pick(1'b0, 2'h2);
    open_rd();
    `CHK("awake", 1'b0, stby)
    `CHK("fck_drv", 1'b0, fck_oe_n)
    fpga.ticks(63);
    cyc(8);
    `CHK("ceo_63", 1'b1, ceo_n)
    fpga.ticks(1);
    cyc(8);
    `CHK("ceo_64", 1'b0, ceo_n)
    `CHK("up_drv", 1'b0, up_oe_n)
    for (int a = 0; a < 64; a++)
      `CHK("pword", wexp(2, a), fpga.got[a])
    fpga.sel(1'b0, 1'b0);
    cyc(8);
    `CHK("ceo_oe", 1'b1, ceo_n)
    `CHK("d0_oe", 1'b1, d0_oe_n)
    `CHK("fck_oe", 1'b1, fck_oe_n)
    open_rd();
    fpga.ticks(3);
    fpga.bsy(1'b1);
    cyc(4);
    fpga.ticks(3);
    cyc(8);
    `CHK("stall", 3, fpga.got.size())
    fpga.bsy(1'b0);
    cyc(4);
    fpga.ticks(1);
    cyc(8);
    `CHK("restart", wexp(2, 0), fpga.got[0])
    `CHK("resume", wexp(2, 3), fpga.got[3])
    $display("test parallel done");
    fpga.sel(1'b1, 1'b1);
    cyc(8);
    ser = 1'b1;
    pick(1'b1, 2'h0);
    open_rd();
    fpga.ticks(16);
    cyc(8);
    `CHK("sword0", wexp(1, 0), fpga.got[0])
    `CHK("sword1", wexp(1, 1), fpga.got[1])
    `CHK("up_rel", 1'b1, up_oe_n)
    fpga.sel(1'b1, 1'b1);
    cyc(8);
    ser = 1'b0;
    clk_int = 1'b1;
    open_rd();
    cyc(40);
    `CHK("osc0", wexp(1, 0), fpga.got[0])
    `CHK("osc1", wexp(1, 1), fpga.got[1])
    ckoe = 1'b0;
    cyc(1);
    `CHK("fck_off", 1'b1, fck_oe_n)
    ckoe = 1'b1;
    fpga.sel(1'b1, 1'b1);
    cyc(8);
    `CHK("stby_back", 1'b1, stby)
    clk_int = 1'b0;
    clk_en = 1'b0;
    fpga.sel(1'b0, 1'b1);
    cyc(8);
    `CHK("frozen", 1'b1, stby)
    clk_en = 1'b1;
    cyc(8);
    `CHK("thawed", 1'b0, stby)
    fpga.sel(1'b1, 1'b1);
    cyc(8);
    $display("test serial and oscillator done");
    reload = 1'b1;
    cyc(1);
    reload = 1'b0;
    n = 0;
    repeat (40)
    begin
      n += int'(!cf_oe_n);
      cyc(1);
    end
    `CHK("pulse_len", int'(cpr_pkg::CFG_PULSE_CYC), n)
    `CHK("pulse_lvl", 1'b0, cf_out)
    rst_n = 1'b0;
    cyc(2);
    `CHK("rst2_drive", 1'b0, oe_n)
    rst_n = 1'b1;
    cyc(6);
    `CHK("rst2_free", 1'b1, oe_n)
    $display("test pulse and reset done");
    stop_test();
  end
endmodule // tb_config_prom_readout_control
